// *** verilog/timer_pkg.sv ***
package timer_pkg;
  // link addresses of the timer: three count ports and one control port
  localparam logic [7:0] CNT0_ADDR = 8'hd0;
  localparam logic [7:0] COUNTER_ONE_COUNT_PORT = 8'hd2;
  localparam logic [7:0] CNT2_ADDR = 8'hd4;
  localparam logic [7:0] TIMER_CONTROL_WORD_PORT = 8'hd6;
  localparam logic [4:0] BLOCK_BASE = 5'h1a;
  localparam logic [1:0] CTRL_SEL = 2'h3;
  // control word fields
  localparam int SEL_LO = 6;
  localparam int RW_LO = 4;
  localparam int MODE_LO = 1;
  typedef enum logic [1:0] {
    BYTES_LATCH = 2'h0,
    BYTES_LSB = 2'h1,
    BYTES_MSB = 2'h2,
    BYTES_BOTH = 2'h3
  } byte_mode_t;
  localparam logic [7:0] LATCH_CNT1_WORD = 8'h40;
  localparam logic [1:0] MODE_RATE = 2'h2;
  localparam logic [1:0] MODE_SQUARE = 2'h3;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [1:0] BYTES_RESET = 2'h3;
  // count clock rates
  localparam int TIMER_CLK_HZ = 1230000;
  localparam int CNT1_CLK_HZ = 153600;
  localparam int FAST_CLK_HZ = 2460000;
  // divisor for a baud rate and clock multiplier of 1, 16 or 64
  function automatic int baud_divisor(input int clk_hz, input int baud, input int mult);
    return clk_hz / (baud * mult);
  endfunction
  // count for an interval in microseconds at a given count clock
  function automatic longint interval_count(input longint us, input longint clk_hz);
    return (us * clk_hz) / 64'd1000000;
  endfunction
  // host register map on the avalon side
  localparam logic [3:0] AV_CMD_OFS = 4'h0;
  localparam logic [3:0] AV_RESULT_OFS = 4'h4;
  localparam logic [3:0] AV_CFG_OFS = 4'h8;
  localparam logic [2:0] CFG_RESET = 3'h3;
  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_READ = 2'h1,
    OP_LATCH_READ = 2'h2,
    OP_LOAD16 = 2'h3
  } op_t;
endpackage

// *** verilog/timer_link_if.sv ***
`timescale 1ns/1ps
interface timer_link_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic ack;
  logic gate0;
  logic gate1;
  modport dev (input addr, input wdata, input wr, input rd, input gate0, input gate1,
               output rdata, output ack);
  modport host (output addr, output wdata, output wr, output rd, output gate0,
                output gate1, input rdata, input ack);
endinterface

// *** verilog/timer_device.sv ***
`timescale 1ns/1ps
module timer_device (
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  timer_link_if.dev LINK,
  input wire logic [2:0] CNT_TICK_I,
  input wire logic CASCADE_I,
  output logic FIRST_TIMER_IRQ_OUT_O,
  output logic SECOND_TIMER_IRQ_OUT_O,
  output logic SERIAL_TX_CLOCK_O,
  output logic SERIAL_RX_CLOCK_O
);
  import timer_pkg::*;

  logic [7:0] rdata_reg;
  logic ack_reg;
  logic out0_prev_reg;
  logic [2:0] out_vec;
  logic [7:0] rbyte [3];

  wire blk_hit = (LINK.addr[7:3] == BLOCK_BASE) && !LINK.addr[0];
  wire [1:0] port_sel = LINK.addr[2:1];
  wire ctrl_wr = LINK.wr && blk_hit && (port_sel == CTRL_SEL);
  wire [1:0] word_sel = LINK.wdata[SEL_LO+:2];
  wire out0_rise = out_vec[0] && !out0_prev_reg;
  // chained use: counter 1 counts periods of counter 0
  wire [2:0] tick_w = {CNT_TICK_I[2], CASCADE_I ? out0_rise : CNT_TICK_I[1],
                       CNT_TICK_I[0]};
  wire [2:0] gate_w = {1'b1, LINK.gate1, LINK.gate0};
  wire cnt_rd = LINK.rd && blk_hit && (port_sel != CTRL_SEL);
  wire [7:0] rd_sel = (port_sel == 2'h0) ? rbyte[0] : (port_sel == 2'h1) ? rbyte[1] : rbyte[2];

  for (genvar i = 0; i < 3; i++) begin : g_cnt
    logic [15:0] cnt_reg;
    logic [15:0] reload_reg;
    logic [15:0] hold_reg;
    logic [7:0] lsb_reg;
    logic [2:0] mode_reg;
    logic [1:0] rwm_reg;
    logic wr_ff_reg;
    logic rd_ff_reg;
    logic latched_reg;
    logic armed_reg;
    logic out_reg;
    wire ctrl_hit = ctrl_wr && (word_sel == 2'(i));
    wire data_wr = LINK.wr && blk_hit && (port_sel == 2'(i));
    wire data_rd = LINK.rd && blk_hit && (port_sel == 2'(i));
    wire [1:0] new_rwm = LINK.wdata[RW_LO+:2];
    wire [2:0] new_mode = LINK.wdata[MODE_LO+:3];
    wire is_rate = mode_reg[1:0] == MODE_RATE;
    wire is_sq = mode_reg[1:0] == MODE_SQUARE;
    wire run = tick_w[i] && gate_w[i] && armed_reg;
    wire [15:0] cnt_dec = cnt_reg - 16'h0001;
    wire [15:0] src = latched_reg ? hold_reg : cnt_reg;
    wire rd_hi = (rwm_reg == BYTES_MSB) || ((rwm_reg == BYTES_BOTH) && rd_ff_reg);
    wire [15:0] wr_val = (rwm_reg == BYTES_LSB) ? {8'h00, LINK.wdata} :
                         (rwm_reg == BYTES_MSB) ? {LINK.wdata, 8'h00} :
                         {LINK.wdata, lsb_reg};
    wire wr_done = (rwm_reg != BYTES_BOTH) || wr_ff_reg;
    assign rbyte[i] = rd_hi ? src[15:8] : src[7:0];
    assign out_vec[i] = out_reg;

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
        cnt_reg <= 16'h0000;
        reload_reg <= 16'h0000;
        hold_reg <= 16'h0000;
        lsb_reg <= 8'h00;
        mode_reg <= MODE_RESET;
        rwm_reg <= BYTES_RESET;
        wr_ff_reg <= 1'b0;
        rd_ff_reg <= 1'b0;
        latched_reg <= 1'b0;
        armed_reg <= 1'b0;
        out_reg <= 1'b1;
      end else begin
        // the count divides the count clock by n; a count of zero means 65536
        if (run) begin
          if (cnt_reg == 16'h0001 && (is_rate || is_sq)) begin
            cnt_reg <= reload_reg;
            out_reg <= 1'b1;
          end else begin
            cnt_reg <= cnt_dec;
            if (is_rate) begin
              out_reg <= (cnt_reg != 16'h0002);
            end else if (is_sq) begin
              out_reg <= (cnt_dec > {1'b0, reload_reg[15:1]});
            end else if (cnt_reg == 16'h0001) begin
              out_reg <= 1'b1;
            end
          end
        end else if (!gate_w[i] && (is_rate || is_sq)) begin
          out_reg <= 1'b1;
        end
        if (ctrl_hit) begin
          if (new_rwm == BYTES_LATCH) begin
            // a second latch before the read finishes keeps the first snapshot
            if (!latched_reg) begin
              hold_reg <= cnt_reg;
              latched_reg <= 1'b1;
            end
          end else begin
            mode_reg <= new_mode;
            rwm_reg <= new_rwm;
            wr_ff_reg <= 1'b0;
            rd_ff_reg <= 1'b0;
            latched_reg <= 1'b0;
            armed_reg <= 1'b0;
            out_reg <= (new_mode[1:0] == MODE_RATE) || (new_mode[1:0] == MODE_SQUARE);
          end
        end else if (data_wr) begin
          if (!wr_done) begin
            lsb_reg <= LINK.wdata;
            wr_ff_reg <= 1'b1;
          end else begin
            wr_ff_reg <= 1'b0;
            reload_reg <= wr_val;
            cnt_reg <= wr_val;
            armed_reg <= 1'b1;
            if (!(is_rate || is_sq)) begin
              out_reg <= 1'b0;
            end
          end
        end else if (data_rd) begin
          // the byte pointer moves on reads and is cleared by a new mode word, so a half read stays pending across data writes and latches
          if (rwm_reg == BYTES_BOTH) begin
            rd_ff_reg <= !rd_ff_reg;
          end
          if (rwm_reg != BYTES_BOTH || rd_ff_reg) begin
            latched_reg <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rdata_reg <= 8'h00;
      ack_reg <= 1'b0;
      out0_prev_reg <= 1'b1;
    end else begin
      ack_reg <= LINK.wr || LINK.rd;
      rdata_reg <= cnt_rd ? rd_sel : 8'h00;
      out0_prev_reg <= out_vec[0];
    end
  end

  assign LINK.rdata = rdata_reg;
  assign LINK.ack = ack_reg;
  assign FIRST_TIMER_IRQ_OUT_O = out_vec[0];
  assign SECOND_TIMER_IRQ_OUT_O = out_vec[1];
  assign SERIAL_TX_CLOCK_O = out_vec[2];
  assign SERIAL_RX_CLOCK_O = out_vec[2];
endmodule

// *** verilog/timer_host.sv ***
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
// Operation
// - direct reads need counter stopped by gate; counter 2 has no gate here, its gate is tied high
// - latch word to control port, then read
// - finish a started read before other operations
// - read bytes match programmed byte mode
// - latch word 40h, read lsb then msb
// - counters drive two interrupts and baud clock
// - loaded count divides counter input clock
// - synchronous divisor is clock over baud
// - asynchronous divisor also divides by multiplier
// - doubled input clock doubles every divisor; host doubles counter 2 loads only
// - counters 0,1 clocked separately, may chain
// - interval timer: mode 0, count T times C
// - three count ports plus one control port
module timer_host (
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  timer_link_if.host LINK,
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output logic BUSY_O
);
  import timer_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_ISSUE = 3'b010,
    S_WAIT = 3'b100
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [2:0] cfg_reg;
  logic busy_reg;

  logic [15:0] result_reg;
  timer_pkg::op_t op_reg;
  logic [1:0] idx_reg;
  logic [7:0] byte_reg;
  logic [15:0] value_reg;
  logic [1:0] phase_reg;

  logic [7:0] addr_reg;
  logic [7:0] wdata_reg;
  logic wr_reg;
  logic rd_reg;

  wire busy = state_reg != S_IDLE;
  wire req = AVS_READ_I || AVS_WRITE_I;
  wire cmd_sel = AVS_ADDRESS_I == AV_CMD_OFS;
  wire res_sel = AVS_ADDRESS_I == AV_RESULT_OFS;
  wire cfg_sel = AVS_ADDRESS_I == AV_CFG_OFS;
  // a new command stalls the bus until the previous sequence has ended
  wire blocked = AVS_WRITE_I && cmd_sel && busy;
  wire accept = req && wait_reg && !blocked;
  wire done = req && !wait_reg;
  wire cmd_take = done && AVS_WRITE_I && cmd_sel;
  wire [31:0] res_word = {15'h0000, busy, result_reg};
  wire [31:0] cfg_word = {29'h00000000, cfg_reg};
  wire [31:0] rd_mux = res_sel ? res_word : cfg_sel ? cfg_word : 32'h00000000;

  // config bit 2 says the count clock runs at twice the nominal rate
  wire fast_clk = cfg_reg[2];
  wire [15:0] cmd_value = AVS_WRITEDATA_I[31:16];
  wire [1:0] cmd_idx = AVS_WRITEDATA_I[9:8];
  // only counter 2 feeds the baud clock, so only its loads are doubled
  wire dbl = fast_clk && (cmd_idx == 2'h2) && (AVS_WRITEDATA_I[11:10] == OP_LOAD16);
  wire [15:0] load_value = dbl ? {cmd_value[14:0], 1'b0} : cmd_value;

  wire [7:0] cnt_addr = {BLOCK_BASE, idx_reg, 1'b0};
  wire [1:0] last_phase = (op_reg == OP_LATCH_READ || op_reg == OP_LOAD16) ? 2'h2 : 2'h0;
  wire seq_end = phase_reg == last_phase;
  wire is_read = (op_reg == OP_READ) || (op_reg == OP_LATCH_READ && phase_reg != 2'h0);
  // latch word names the counter with both byte bits clear
  wire [7:0] latch_word = {idx_reg, BYTES_LATCH, 4'h0};
  // the first access of a latched read or a load goes to the control port
  wire first_phase = phase_reg == 2'h0;
  wire ctrl_first = first_phase && (op_reg != OP_WRITE) && (op_reg != OP_READ);
  wire [7:0] issue_addr = ctrl_first ? TIMER_CONTROL_WORD_PORT : cnt_addr;
  wire [7:0] issue_data = (op_reg == OP_LATCH_READ) ? latch_word :
                          (op_reg != OP_LOAD16) ? byte_reg :
                          (phase_reg == 2'h0) ? byte_reg :
                          (phase_reg == 2'h1) ? value_reg[7:0] : value_reg[15:8];

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE: begin
        if (cmd_take) begin
          state_next = S_ISSUE;
        end
      end
      S_ISSUE: begin
        // one idle cycle after each answer keeps strobes three cycles apart
        state_next = S_WAIT;
      end
      S_WAIT: begin
        if (LINK.ack) begin
          state_next = seq_end ? S_IDLE : S_ISSUE;
        end
      end
      // a corrupted one-hot code falls back to idle
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      // waitrequest idles high so nothing completes before it is accepted
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
      // gates start open, so counters 0 and 1 run as soon as they are loaded
      cfg_reg <= CFG_RESET;
    end else begin
      wait_reg <= !accept;
      if (accept && AVS_READ_I) begin
        rdata_reg <= rd_mux;
      end
      if (done && AVS_WRITE_I && cfg_sel) begin
        cfg_reg <= AVS_WRITEDATA_I[2:0];
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_reg <= S_IDLE;
      op_reg <= OP_WRITE;
      idx_reg <= 2'h0;
      byte_reg <= 8'h00;
      value_reg <= 16'h0000;
      phase_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      if (state_reg == S_IDLE && cmd_take) begin
        op_reg <= op_t'(AVS_WRITEDATA_I[11:10]);
        idx_reg <= cmd_idx;
        byte_reg <= AVS_WRITEDATA_I[7:0];
        value_reg <= load_value;
        phase_reg <= 2'h0;
      end else if (state_reg == S_WAIT && LINK.ack && !seq_end) begin
        // phase steps through control word, low byte, high byte
        phase_reg <= phase_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      result_reg <= 16'h0000;
    end else if (state_reg == S_WAIT && LINK.ack && is_read) begin
      // first byte of a latched read is the low half
      if (op_reg == OP_READ) begin
        result_reg <= {8'h00, LINK.rdata};
      end else if (phase_reg == 2'h1) begin
        result_reg[7:0] <= LINK.rdata;
      end else begin
        result_reg[15:8] <= LINK.rdata;
      end
    end
  end

  // link strobes last one cycle and the link stays idle until the answer
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else begin
      wr_reg <= (state_reg == S_ISSUE) && !is_read;
      rd_reg <= (state_reg == S_ISSUE) && is_read;
      if (state_reg == S_ISSUE) begin
        addr_reg <= issue_addr;
        wdata_reg <= issue_data;
      end
    end
  end

  // busy is registered so the status pin comes straight from a flop
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= state_next != S_IDLE;
    end
  end

  assign LINK.addr = addr_reg;
  assign LINK.wdata = wdata_reg;
  assign LINK.wr = wr_reg;
  assign LINK.rd = rd_reg;
  assign LINK.gate0 = cfg_reg[0];
  assign LINK.gate1 = cfg_reg[1];
  assign AVS_READDATA_O = rdata_reg;
  assign AVS_WAITREQUEST_O = wait_reg;
  assign BUSY_O = busy_reg;
endmodule

// *** verification/timer_link_sva.sv ***
`timescale 1ns/1ps
module timer_link_sva (
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic ack,
  input wire logic gate0,
  input wire logic gate1
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I);
  chk_ack_one_pulse: assert property ((wr || rd) |=> ack ##1 !ack)
    else $error("ack missing or too long");
  chk_ack_has_cause: assert property (ack |-> $past(wr) || $past(rd))
    else $error("ack without strobe");
  chk_strobe_gap: assert property ((wr || rd) |=> !(wr || rd) [*2])
    else $error("strobes too close");
  chk_strobe_excl: assert property (!(wr && rd))
    else $error("read and write together");
  chk_idle_rdata: assert property (!ack |-> rdata == 8'h00)
    else $error("read byte outside ack");
  chk_unmapped_zero: assert property (ack && $past(rd) && $past(addr) == 8'hd6
    |-> rdata == 8'h00)
    else $error("control port read not zero");
  // a two-byte load must put lsb then msb on the same count port
  chk_load_order: assert property (wr && addr == 8'hd6 && wdata[5:4] == 2'h3
    && wdata[7:6] != 2'h3 |-> ##3 (wr && addr[7:3] == 5'h1a && addr[0] == 1'b0
    && addr != 8'hd6) ##3 (wr && addr == $past(addr, 3)))
    else $error("count bytes not paired");
  chk_latch_pair: assert property ((wr && addr == 8'hd6 && wdata == 8'h40) ##3
    (rd && addr == 8'hd2) |-> ##3 (rd && addr == 8'hd2))
    else $error("latched read not completed");
endmodule

// *** verification/test_interval_timer_read_and_divisor.sv ***
`timescale 1ns/1ps
module test_interval_timer_read_and_divisor;
  import timer_pkg::*;
  logic MCLK_I = 1'b0;
  logic ARST_N_I = 1'b0;
  logic [3:0] av_a = 4'h0;
  logic av_r = 1'b0;
  logic av_w = 1'b0;
  logic [31:0] av_d = 32'h0;
  logic [31:0] av_rd;
  logic [31:0] av_q;
  logic av_wait;
  logic busy;
  logic tk = 1'b0;
  logic tk_en = 1'b0;
  logic casc = 1'b0;
  logic [3:0] outs;
  int err_total = 0;
  int num_checks = 0;
  int p;
  int q;
  timer_link_if link();
  timer_device i_timer_device (.MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I), .LINK(link),
    .CNT_TICK_I({3{tk}}), .CASCADE_I(casc), .FIRST_TIMER_IRQ_OUT_O(outs[0]),
    .SECOND_TIMER_IRQ_OUT_O(outs[1]), .SERIAL_TX_CLOCK_O(outs[2]),
    .SERIAL_RX_CLOCK_O(outs[3]));
  timer_host i_timer_host (.MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I), .LINK(link),
    .AVS_ADDRESS_I(av_a), .AVS_READ_I(av_r), .AVS_WRITE_I(av_w), .AVS_WRITEDATA_I(av_d),
    .AVS_READDATA_O(av_rd), .AVS_WAITREQUEST_O(av_wait), .BUSY_O(busy));
  timer_link_sva i_timer_link_sva (.MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I),
    .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd),
    .rdata(link.rdata), .ack(link.ack), .gate0(link.gate0), .gate1(link.gate1));
  initial begin
    forever #12.5 MCLK_I = ~MCLK_I;
  end
  // count clock enable on every other cycle keeps ticks one cycle wide
  always @(posedge MCLK_I) tk <= tk_en & ~tk;
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 2000) begin
      cmp(32'h0, 32'h1);
      results();
    end
  endtask
  task automatic av(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge MCLK_I);
    av_a <= a;
    av_w <= we;
    av_r <= !we;
    av_d <= d;
    // the request stands until a rising edge that sees waitrequest low
    do begin
      @(posedge MCLK_I);
      n++;
    end while (av_wait !== 1'b0 && n < 2000);
    av_q = av_rd;
    av_w <= 1'b0;
    av_r <= 1'b0;
    tmo(n);
  endtask
  // runs one link sequence and leaves the result register in av_q
  task automatic cmd(input logic [1:0] op, input logic [1:0] ix, input logic [7:0] b,
                     input logic [15:0] v);
    int n;
    n = 0;
    av(1'b1, AV_CMD_OFS, {v, 4'h0, op, ix, b});
    do begin
      @(negedge MCLK_I);
      n++;
    end while (busy !== 1'b0 && n < 2000);
    tmo(n);
    av(1'b0, AV_RESULT_OFS, 32'h0);
  endtask
  // ticks between two falling edges of one counter output
  task automatic period(input int k, output int c);
    int f, n;
    logic prev;
    f = 0;
    n = 0;
    c = 0;
    prev = outs[k];
    while (f < 2 && n < 2000) begin
      @(negedge MCLK_I);
      n++;
      if (f == 1 && tk) c++;
      if (prev && !outs[k]) f++;
      prev = outs[k];
    end
    tmo(n);
    @(posedge MCLK_I);
  endtask
  initial begin
    repeat (5) @(posedge MCLK_I);
    ARST_N_I <= 1'b1;
    av(1'b0, AV_CFG_OFS, 32'h0);
    cmp(av_q, 32'h3);
    av(1'b0, 4'hc, 32'h0);
    cmp(av_q, 32'h0);
    cmd(2'h1, 2'h3, 8'h00, 16'h0);
    cmp({24'h0, av_q[7:0]}, 32'h0);
    $display("test reset_map done");
    av(1'b1, AV_CFG_OFS, 32'h2);
    tk_en <= 1'b1;
    cmd(2'h3, 2'h0, 8'h34, 16'h0a55);
    cmp({31'h0, link.gate0}, 32'h0);
    cmd(2'h1, 2'h0, 8'h00, 16'h0);
    cmp({24'h0, av_q[7:0]}, 32'h55);
    cmd(2'h1, 2'h0, 8'h00, 16'h0);
    cmp({24'h0, av_q[7:0]}, 32'h0a);
    $display("test gated_read done");
    tk_en <= 1'b0;
    cmd(2'h3, 2'h1, 8'h74, 16'h1234);
    // a command written while busy is held off until the sequence ends
    av(1'b1, AV_CMD_OFS, {16'h0, 4'h0, 2'h2, 2'h1, 8'h00});
    cmd(2'h2, 2'h1, 8'h00, 16'h0);
    cmp({16'h0, av_q[15:0]}, 32'h1234);
    cmd(2'h0, 2'h3, LATCH_CNT1_WORD, 16'h0);
    tk_en <= 1'b1;
    repeat (40) @(posedge MCLK_I);
    tk_en <= 1'b0;
    cmd(2'h1, 2'h1, 8'h00, 16'h0);
    cmp({24'h0, av_q[7:0]}, 32'h34);
    cmd(2'h1, 2'h1, 8'h00, 16'h0);
    cmp({24'h0, av_q[7:0]}, 32'h12);
    cmd(2'h2, 2'h1, 8'h00, 16'h0);
    cmp({31'h0, av_q[15:0] < 16'h1234}, 32'h1);
    $display("test latched_read done");
    av(1'b1, AV_CFG_OFS, 32'h3);
    tk_en <= 1'b1;
    cmd(2'h3, 2'h0, 8'h34, 16'd5);
    period(0, p);
    cmp(p, 32'd5);
    cmd(2'h3, 2'h1, 8'h74, 16'd3);
    period(1, p);
    cmp(p, 32'd3);
    cmd(2'h3, 2'h2, 8'hb4, 16'(TIMER_CLK_HZ / 76800));
    period(2, p);
    cmp(p, 32'd16);
    cmp({31'h0, outs[3]}, {31'h0, outs[2]});
    cmd(2'h3, 2'h2, 8'hb4, 16'(TIMER_CLK_HZ / (4800 * 64)));
    period(2, p);
    cmp(p, 32'd4);
    av(1'b1, AV_CFG_OFS, 32'h7);
    cmd(2'h3, 2'h2, 8'hb4, 16'd4);
    period(2, p);
    cmp(p, 32'd8);
    casc <= 1'b1;
    cmd(2'h3, 2'h0, 8'h34, 16'd3);
    cmd(2'h3, 2'h1, 8'h74, 16'd2);
    period(1, p);
    cmp(p, 32'd6);
    $display("test divisors done");
    casc <= 1'b0;
    tk_en <= 1'b0;
    cmd(2'h3, 2'h0, 8'h30, 16'(interval_count(10, TIMER_CLK_HZ)));
    cmp({31'h0, outs[0]}, 32'h0);
    tk_en <= 1'b1;
    p = 0;
    q = 0;
    while (!outs[0] && q < 2000) begin
      @(negedge MCLK_I);
      q++;
      if (tk) p++;
    end
    tmo(q);
    cmp(p, 32'd12);
    repeat (40) @(posedge MCLK_I);
    cmp({31'h0, outs[0]}, 32'h1);
    $display("test interval done");
    results();
  end
endmodule
